// *** rtl/aaop_core.sv ***
// accumulator add/and execution datapath with status flags
// assumes decode supplies one request per cycle and the memory byte read
`timescale 1ns/1ps
`default_nettype none

module aaop_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // instruction request
    input wire logic req_valid,
    input wire aaop_pkg::aaop_req_s req,
    // direct accumulator load from other instructions
    input wire logic acc_load,
    input wire logic [aaop_pkg::DATA_W-1:0] acc_load_data,
    // memory write back
    output logic mem_wr,
    output logic [aaop_pkg::DATA_W-1:0] mem_wdata,
    // architectural state
    output logic [aaop_pkg::DATA_W-1:0] accumulator_reg,
    output aaop_pkg::aaop_flags_s flags
);

    // reset release path
    logic rst_meta;
    logic rst_sync_n;
    // decoded request
    aaop_pkg::aaop_op_e op;
    logic wr_mem;
    logic wr_acc;
    logic upd_zero;
    logic upd_arith;
    logic [aaop_pkg::DATA_W-1:0] alu_b;
    aaop_pkg::aaop_res_s alu_res;
    // next state
    logic [aaop_pkg::DATA_W-1:0] next_acc;
    aaop_pkg::aaop_flags_s next_flags;
    logic next_mem_wr;
    logic [aaop_pkg::DATA_W-1:0] next_mem_wdata;

    function automatic logic op_writes_mem(
        input aaop_pkg::aaop_op_e o
    );
        logic hit;
        unique case (o)
            aaop_pkg::AAOP_NOP: hit = 1'b0;
            aaop_pkg::AAOP_ADD_MEM: hit = 1'b1;
            aaop_pkg::AAOP_AND_MEM: hit = 1'b0;
            aaop_pkg::AAOP_AND_IMM: hit = 1'b0;
            aaop_pkg::AAOP_ANDM_MEM: hit = 1'b1;
            // codes past the enum do nothing
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : op_writes_mem

    function automatic logic op_writes_acc(
        input aaop_pkg::aaop_op_e o
    );
        logic hit;
        unique case (o)
            aaop_pkg::AAOP_NOP: hit = 1'b0;
            aaop_pkg::AAOP_ADD_MEM: hit = 1'b0;
            aaop_pkg::AAOP_AND_MEM: hit = 1'b1;
            aaop_pkg::AAOP_AND_IMM: hit = 1'b1;
            aaop_pkg::AAOP_ANDM_MEM: hit = 1'b0;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : op_writes_acc

    function automatic logic op_sets_zero(
        input aaop_pkg::aaop_op_e o
    );
        logic hit;
        unique case (o)
            aaop_pkg::AAOP_NOP: hit = 1'b0;
            aaop_pkg::AAOP_ADD_MEM: hit = 1'b1;
            aaop_pkg::AAOP_AND_MEM: hit = 1'b1;
            aaop_pkg::AAOP_AND_IMM: hit = 1'b1;
            aaop_pkg::AAOP_ANDM_MEM: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : op_sets_zero

    function automatic logic op_sets_arith(
        input aaop_pkg::aaop_op_e o
    );
        logic hit;
        unique case (o)
            aaop_pkg::AAOP_NOP: hit = 1'b0;
            aaop_pkg::AAOP_ADD_MEM: hit = 1'b1;
            aaop_pkg::AAOP_AND_MEM: hit = 1'b0;
            aaop_pkg::AAOP_AND_IMM: hit = 1'b0;
            aaop_pkg::AAOP_ANDM_MEM: hit = 1'b0;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : op_sets_arith

    function automatic logic [aaop_pkg::DATA_W-1:0] pick_operand(
        input aaop_pkg::aaop_op_e o,
        input logic [aaop_pkg::DATA_W-1:0] mem_byte,
        input logic [aaop_pkg::DATA_W-1:0] imm_byte
    );
        logic [aaop_pkg::DATA_W-1:0] pick;
        if (o == aaop_pkg::AAOP_AND_IMM) begin
            pick = imm_byte;
        end else begin
            pick = mem_byte;
        end
        return pick;
    endfunction : pick_operand

    // reset released through two flops to avoid a partial release
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // request decode; an idle cycle reads as a nop
    always_comb begin
        op = req_valid ? req.op : aaop_pkg::AAOP_NOP;
        wr_mem = op_writes_mem(op);
        wr_acc = op_writes_acc(op);
        upd_zero = op_sets_zero(op);
        upd_arith = op_sets_arith(op);
        alu_b = pick_operand(op, req.mem_data, req.imm_data);
    end

    // add and and share one operand path
    aaop_alu u_alu (
        .opa(accumulator_reg),
        .opb(alu_b),
        .sel_add(upd_arith),
        .res(alu_res)
    );

    // and result into accumulator
    // a load in the same cycle loses: the and result is the newer value
    always_comb begin
        if (wr_acc) begin
            next_acc = alu_res.result;
        end else if (acc_load) begin
            next_acc = acc_load_data;
        end else begin
            next_acc = accumulator_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            accumulator_reg <= aaop_pkg::ACC_RESET;
        end else begin
            accumulator_reg <= next_acc;
        end
    end

    always_comb begin
        next_flags = flags;
        if (upd_arith) begin
            next_flags.overflow_flag = alu_res.overflow_flag;
            next_flags.aux_carry_flag = alu_res.aux_carry_flag;
            next_flags.carry_flag = alu_res.carry_flag;
        end
        if (upd_zero) begin
            next_flags.zero_flag = alu_res.zero_flag;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            flags <= aaop_pkg::FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // one cycle write strobe
    // data kept between writes so a late store still sees it
    always_comb begin
        next_mem_wr = wr_mem;
        if (wr_mem) begin
            next_mem_wdata = alu_res.result;
        end else begin
            next_mem_wdata = mem_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mem_wr <= 1'b0;
            mem_wdata <= aaop_pkg::ZERO_BYTE;
        end else begin
            mem_wr <= next_mem_wr;
            mem_wdata <= next_mem_wdata;
        end
    end

endmodule : aaop_core
`default_nettype wire

// *** rtl/aaop_pkg.sv ***
// shared types and constants for the accumulator add/and datapath
// assumes one core clock and an operand fetch done outside this block
package aaop_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned NIBBLE_W = 4;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    typedef enum logic [2:0] {
        AAOP_NOP,
        AAOP_ADD_MEM,
        AAOP_AND_MEM,
        AAOP_AND_IMM,
        AAOP_ANDM_MEM
    } aaop_op_e;

    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } aaop_flags_s;

    localparam aaop_flags_s FLAGS_RESET = '{
        overflow_flag: 1'b0,
        zero_flag: 1'b0,
        aux_carry_flag: 1'b0,
        carry_flag: 1'b0
    };

    typedef struct packed {
        aaop_op_e op;
        logic [DATA_W-1:0] mem_data;
        logic [DATA_W-1:0] imm_data;
    } aaop_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic overflow_flag;
        logic aux_carry_flag;
        logic carry_flag;
        logic zero_flag;
    } aaop_res_s;

endpackage : aaop_pkg

// *** rtl/aaop_alu.sv ***
// combinational add and and unit with flag terms
// assumes operands are stable for the cycle the request is taken
`timescale 1ns/1ps
`default_nettype none

module aaop_alu (
    // operands and add select
    input wire logic [aaop_pkg::DATA_W-1:0] opa,
    input wire logic [aaop_pkg::DATA_W-1:0] opb,
    input wire logic sel_add,
    // result and flag terms
    output aaop_pkg::aaop_res_s res
);

    logic [aaop_pkg::DATA_W:0] sum;
    logic [aaop_pkg::NIBBLE_W:0] low_sum;

    always_comb begin
        sum = {1'b0, opa} + {1'b0, opb};
        low_sum = {1'b0, opa[aaop_pkg::NIBBLE_W-1:0]}
                + {1'b0, opb[aaop_pkg::NIBBLE_W-1:0]};
        res = '0;
        if (sel_add) begin
            res.result = sum[aaop_pkg::DATA_W-1:0];
            res.carry_flag = sum[aaop_pkg::DATA_W];
            res.aux_carry_flag = low_sum[aaop_pkg::NIBBLE_W];
            // signed overflow: like signs in, other sign out
            res.overflow_flag =
                (opa[aaop_pkg::DATA_W-1] == opb[aaop_pkg::DATA_W-1])
                && (sum[aaop_pkg::DATA_W-1] != opa[aaop_pkg::DATA_W-1]);
        end else begin
            res.result = opa & opb;
        end
        res.zero_flag = (res.result == aaop_pkg::ZERO_BYTE);
    end

endmodule : aaop_alu
`default_nettype wire

// *** testbench/aaop_core_sva.sv ***
// checker on the aaop_core ports
// assumes results land on the edge that takes the request
`timescale 1ns/1ps
`default_nettype none
module aaop_core_sva (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // request and results
    input wire logic req_valid,
    input wire aaop_pkg::aaop_req_s req,
    input wire logic acc_load,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] accumulator_reg,
    input wire aaop_pkg::aaop_flags_s flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic [7:0] a = accumulator_reg;
    wire logic [7:0] m = req.mem_data;
    wire logic [2:0] op = req_valid ? req.op : 3'h0;
    wire logic [8:0] sum = a + m;
    wire logic [4:0] nib = a[3:0] + m[3:0];
    wire logic [3:0] f_add = {a[7] == m[7] && sum[7] != a[7],
        sum[7:0] == 8'h00, nib[4], sum[8]};
    wire logic [7:0] and_m = a & m;
    wire logic [7:0] and_i = a & req.imm_data;
    wire logic and_z = (op == 3'h3 ? and_i : and_m) == 8'h00;
    wire logic [2:0] held = {flags[3], flags[1:0]};
    AST_ADD_MEM: assert property (op == 3'h1 |=> mem_wr &&
        mem_wdata == 8'($past(sum))) else $error("add write-back");
    AST_ADD_FLG: assert property (op == 3'h1 |=> flags == $past(f_add))
        else $error("add flags");
    AST_AND_MEM: assert property (op == 3'h2 |=> a == $past(and_m))
        else $error("and mem result");
    AST_AND_IMM: assert property (op == 3'h3 |=> a == $past(and_i))
        else $error("and imm result");
    AST_ANDM: assert property (op == 3'h4 |=> mem_wr &&
        mem_wdata == $past(and_m)) else $error("and to mem result");
    AST_AND_FLG: assert property (op inside {3'h2, 3'h3, 3'h4} |=>
        $stable(held) && flags.zero_flag == $past(and_z))
        else $error("and flags");
    AST_ADD_ACC: assert property (op == 3'h1 && !acc_load |=>
        $stable(a)) else $error("add changed accumulator");
    AST_NO_WR: assert property (!(op == 3'h1 || op == 3'h4) |=>
        !mem_wr) else $error("write without a store op");
endmodule : aaop_core_sva
bind aaop_core aaop_core_sva u_aaop_core_sva (.clk_sys(clk_sys), .nrst(nrst),
    .req_valid(req_valid), .req(req), .acc_load(acc_load), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .accumulator_reg(accumulator_reg), .flags(flags));
`default_nettype wire

// *** testbench/aaop_core_tb_top.sv ***
// bench for aaop_core: loads acc, issues one op, checks every output
// assumes the checker is bound from its own file
`timescale 1ns/1ps
`default_nettype none
module aaop_core_tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    aaop_pkg::aaop_req_s req = '0;
    logic acc_load = 1'b0;
    logic [7:0] acc_load_data = 8'h00;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] accumulator_reg;
    aaop_pkg::aaop_flags_s flags;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    always #4 clk_sys = ~clk_sys;
    aaop_core u_aaop_core (.clk_sys(clk_sys), .nrst(nrst),
        .req_valid(req_valid), .req(req), .acc_load(acc_load),
        .acc_load_data(acc_load_data), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .accumulator_reg(accumulator_reg),
        .flags(flags));
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // imm gets ~m so a swapped operand shows up
    task automatic run(input aaop_pkg::aaop_op_e o, input logic [7:0] m,
            input logic [7:0] ld, input logic [20:0] exp);
        @(posedge clk_sys);
        acc_load <= 1'b1;
        acc_load_data <= ld;
        @(posedge clk_sys);
        acc_load <= 1'b0;
        req_valid <= 1'b1;
        req <= '{o, m, ~m};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        #1 chk({mem_wr, mem_wdata, accumulator_reg, flags}, exp);
    endtask : run
    task automatic t_add;
        run(aaop_pkg::AAOP_ADD_MEM, 8'h80, 8'h80, 21'h10080d);
        run(aaop_pkg::AAOP_ADD_MEM, 8'h0f, 8'h01, 21'h110012);
        run(aaop_pkg::AAOP_ADD_MEM, 8'h88, 8'h88, 21'h11088b);
        $display("add test done");
    endtask : t_add
    // ov, aux and carry left by the add must survive the ands
    task automatic t_and;
        run(aaop_pkg::AAOP_AND_MEM, 8'h0f, 8'hf0, 21'h01000f);
        run(aaop_pkg::AAOP_AND_IMM, 8'hdb, 8'h3c, 21'h01024b);
        run(aaop_pkg::AAOP_ANDM_MEM, 8'hff, 8'h24, 21'h12424b);
        run(aaop_pkg::AAOP_ANDM_MEM, 8'h0f, 8'hf0, 21'h100f0f);
        $display("and test done");
    endtask : t_and
    // nop, an idle cycle with a stale op, then and against a load
    task automatic t_idle;
        run(aaop_pkg::AAOP_NOP, 8'h5a, 8'h33, 21'h00033f);
        @(posedge clk_sys);
        req <= '{aaop_pkg::AAOP_ANDM_MEM, 8'hff, 8'h00};
        @(posedge clk_sys);
        #1 chk({mem_wr, mem_wdata, accumulator_reg, flags}, 21'h00033f);
        @(posedge clk_sys);
        acc_load <= 1'b1;
        acc_load_data <= 8'h00;
        req_valid <= 1'b1;
        req <= '{aaop_pkg::AAOP_AND_IMM, 8'h00, 8'h0f};
        @(posedge clk_sys);
        acc_load <= 1'b0;
        req_valid <= 1'b0;
        #1 chk({mem_wr, mem_wdata, accumulator_reg, flags}, 21'h00003b);
        $display("idle test done");
    endtask : t_idle
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 200) begin
            err_total++;
            close_out;
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_add;
        t_and;
        t_idle;
        close_out;
    end
endmodule : aaop_core_tb_top
`default_nettype wire
